// ---- verilog/sbpc_config.sv ----
// Supply brownout and port configuration byte with indirect access.
// Assumes the core drives config_address_sfr / config_data_sfr access
// strobes synchronously and supply comparators are synchronised.
`timescale 1ns/100ps

module sbpc_config
    import sbpc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] device_mode,
    input  wire logic [7:0] config_address_sfr,
    input  wire logic [7:0] config_wdata,
    input  wire logic       config_wr,
    input  wire logic       config_rd,
    input  wire logic [3:0] dig_below,
    input  wire logic [3:0] ana_below,
    output logic [7:0]      config_data_sfr,
    output logic [1:0]      digital_brownout_level,
    output logic [1:0]      analog_brownout_level,
    output logic            analog_brownout_reset_off,
    output logic            digital_brownout_reset_off,
    output logic            port_zero_gpio_select,
    output logic            upper_ports_gpio_select,
    output logic            p0_ext_bus_en,
    output logic            p2_ext_bus_en,
    output logic            p3_strobe_en,
    output logic            brownout_reset,
    output logic            write_rejected
);
    logic [7:0] supply_and_port_config_q;
    logic       prog_mode;
    logic       hit;
    logic       dig_bo;
    logic       ana_bo;
    logic       dig_trip;
    logic       ana_trip;

    // Programming modes unlock the byte
    assign prog_mode = (device_mode == SBPC_MODE_SER_PROG)
                    || (device_mode == SBPC_MODE_PAR_PROG);
    assign hit       = (config_address_sfr == SBPC_CFG_ADDR);

    // Byte reloaded with the erased value on reset; only programming modes may change it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_and_port_config_q <= SBPC_RESET_VALUE;
        end else if (config_wr && hit && prog_mode) begin
            supply_and_port_config_q <= config_wdata;
        end
    end

    // Flag for a write attempted outside programming modes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_rejected <= 1'b0;
        end else begin
            write_rejected <= config_wr && hit && !prog_mode;
        end
    end

    // Indirect read port, any mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            config_data_sfr <= SBPC_UNMAPPED_DATA;
        end else if (config_rd) begin
            config_data_sfr <= hit ? supply_and_port_config_q
                                   : SBPC_UNMAPPED_DATA;
        end
    end

    // Field decode to registered outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            digital_brownout_level     <= SBPC_LVL_2V5;
            analog_brownout_level      <= SBPC_LVL_2V5;
            analog_brownout_reset_off  <= 1'b1;
            digital_brownout_reset_off <= 1'b1;
            port_zero_gpio_select      <= 1'b1;
            upper_ports_gpio_select    <= 1'b1;
        end else begin
            digital_brownout_level     <= supply_and_port_config_q[
                SBPC_DIG_LVL_HI:SBPC_DIG_LVL_LO];
            analog_brownout_level      <= supply_and_port_config_q[
                SBPC_ANA_LVL_HI:SBPC_ANA_LVL_LO];
            analog_brownout_reset_off  <=
                supply_and_port_config_q[SBPC_ANA_OFF_BIT];
            digital_brownout_reset_off <=
                supply_and_port_config_q[SBPC_DIG_OFF_BIT];
            port_zero_gpio_select      <=
                supply_and_port_config_q[SBPC_P0_GPIO_BIT];
            upper_ports_gpio_select    <=
                supply_and_port_config_q[SBPC_P23_GPIO_BIT];
        end
    end

    // Port function enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            p0_ext_bus_en <= 1'b0;
            p2_ext_bus_en <= 1'b0;
            p3_strobe_en  <= 1'b0;
        end else begin
            p0_ext_bus_en <= !supply_and_port_config_q[SBPC_P0_GPIO_BIT];
            p2_ext_bus_en <= !supply_and_port_config_q[SBPC_P23_GPIO_BIT];
            p3_strobe_en  <= !supply_and_port_config_q[SBPC_P0_GPIO_BIT]
                || !supply_and_port_config_q[SBPC_P23_GPIO_BIT];
        end
    end

    // Brownout channels
    sbpc_brownout_chan u_dig (
        .clk        (clk),
        .reset_n    (reset_n),
        .level_sel  (supply_and_port_config_q[
                         SBPC_DIG_LVL_HI:SBPC_DIG_LVL_LO]),
        .reset_off  (supply_and_port_config_q[SBPC_DIG_OFF_BIT]),
        .below_vec  (dig_below),
        .brownout_q (dig_bo)
    );
    sbpc_brownout_chan u_ana (
        .clk        (clk),
        .reset_n    (reset_n),
        .level_sel  (supply_and_port_config_q[
                         SBPC_ANA_LVL_HI:SBPC_ANA_LVL_LO]),
        .reset_off  (supply_and_port_config_q[SBPC_ANA_OFF_BIT]),
        .below_vec  (ana_below),
        .brownout_q (ana_bo)
    );

    // System reset request held while either enabled channel sees low supply
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            brownout_reset <= 1'b0;
        end else begin
            brownout_reset <= dig_bo || ana_bo;
        end
    end

    // Enabled channel whose selected comparator sees low supply
    assign dig_trip = !supply_and_port_config_q[SBPC_DIG_OFF_BIT]
        && sbpc_below(supply_and_port_config_q[
               SBPC_DIG_LVL_HI:SBPC_DIG_LVL_LO], dig_below);
    assign ana_trip = !supply_and_port_config_q[SBPC_ANA_OFF_BIT]
        && sbpc_below(supply_and_port_config_q[
               SBPC_ANA_LVL_HI:SBPC_ANA_LVL_LO], ana_below);

    // Assertions
    property p_write_locked;
        @(posedge clk) disable iff (!reset_n)
        (config_wr && !prog_mode) |=> $stable(supply_and_port_config_q);
    endproperty
    a_write_locked: assert property (p_write_locked)
        else $error("config changed outside programming mode");

    property p_write_taken;
        @(posedge clk) disable iff (!reset_n)
        (config_wr && hit && prog_mode)
            |=> supply_and_port_config_q == $past(config_wdata);
    endproperty
    a_write_taken: assert property (p_write_taken)
        else $error("programming write not stored");

    property p_read_data;
        @(posedge clk) disable iff (!reset_n)
        (config_rd && hit && !config_wr)
            |=> config_data_sfr == supply_and_port_config_q;
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data wrong");

    property p_dig_level;
        @(posedge clk) disable iff (!reset_n)
        digital_brownout_level == $past(
            supply_and_port_config_q[SBPC_DIG_LVL_HI:SBPC_DIG_LVL_LO]);
    endproperty
    a_dig_level: assert property (p_dig_level)
        else $error("digital level mismatch");

    property p_ana_level;
        @(posedge clk) disable iff (!reset_n)
        analog_brownout_level == $past(
            supply_and_port_config_q[SBPC_ANA_LVL_HI:SBPC_ANA_LVL_LO]);
    endproperty
    a_ana_level: assert property (p_ana_level)
        else $error("analog level mismatch");

    property p_ana_off;
        @(posedge clk) disable iff (!reset_n)
        (supply_and_port_config_q[SBPC_ANA_OFF_BIT] && !dig_trip)
            |=> ##1 !brownout_reset;
    endproperty
    a_ana_off: assert property (p_ana_off)
        else $error("analog brownout reset while disabled");

    property p_dig_off;
        @(posedge clk) disable iff (!reset_n)
        (supply_and_port_config_q[SBPC_DIG_OFF_BIT] && !ana_trip)
            |=> ##1 !brownout_reset;
    endproperty
    a_dig_off: assert property (p_dig_off)
        else $error("digital brownout reset while disabled");

    property p_p0_bus;
        @(posedge clk) disable iff (!reset_n)
        !supply_and_port_config_q[SBPC_P0_GPIO_BIT]
            |=> p0_ext_bus_en && p3_strobe_en;
    endproperty
    a_p0_bus: assert property (p_p0_bus)
        else $error("port 0 bus not enabled");

    property p_p2_bus;
        @(posedge clk) disable iff (!reset_n)
        !supply_and_port_config_q[SBPC_P23_GPIO_BIT]
            |=> p2_ext_bus_en && p3_strobe_en;
    endproperty
    a_p2_bus: assert property (p_p2_bus)
        else $error("port 2 bus not enabled");

    property p_bo_hold;
        @(posedge clk) disable iff (!reset_n)
        dig_trip |=> ##1 brownout_reset;
    endproperty
    a_bo_hold: assert property (p_bo_hold)
        else $error("brownout reset not asserted");

    property p_ana_hold;
        @(posedge clk) disable iff (!reset_n)
        ana_trip |=> ##1 brownout_reset;
    endproperty
    a_ana_hold: assert property (p_ana_hold)
        else $error("analog brownout reset not asserted");

    c_prog_write: cover property (@(posedge clk) disable iff (!reset_n)
        config_wr && hit && prog_mode);
    c_user_write: cover property (@(posedge clk) disable iff (!reset_n)
        config_wr && hit && !prog_mode);
    c_brownout: cover property (@(posedge clk) disable iff (!reset_n)
        brownout_reset);
endmodule : sbpc_config

// ---- common/sbpc_pkg.sv ----
// Constants for the supply brownout and port configuration byte.
// Assumes a single 25 MHz clock domain and an 8-bit config bus.
package sbpc_pkg;
    // Configuration address of the byte
    localparam logic [7:0] SBPC_CFG_ADDR      = 8'h7E;
    // Field positions
    localparam int         SBPC_DIG_LVL_HI    = 7;
    localparam int         SBPC_DIG_LVL_LO    = 6;
    localparam int         SBPC_ANA_LVL_HI    = 5;
    localparam int         SBPC_ANA_LVL_LO    = 4;
    localparam int         SBPC_ANA_OFF_BIT   = 3;
    localparam int         SBPC_DIG_OFF_BIT   = 2;
    localparam int         SBPC_P0_GPIO_BIT   = 1;
    localparam int         SBPC_P23_GPIO_BIT  = 0;
    // Erased / default value: all fields at their defaults
    localparam logic [7:0] SBPC_RESET_VALUE   = 8'hFF;
    // Read data for unmapped configuration addresses
    localparam logic [7:0] SBPC_UNMAPPED_DATA = 8'h00;

    // Trip level codes
    typedef enum logic [1:0] {
        SBPC_LVL_4V5 = 2'b00,
        SBPC_LVL_4V2 = 2'b01,
        SBPC_LVL_2V7 = 2'b10,
        SBPC_LVL_2V5 = 2'b11
    } sbpc_level_t;

    // Device operating modes
    typedef enum logic [1:0] {
        SBPC_MODE_USER     = 2'b00,
        SBPC_MODE_SER_PROG = 2'b01,
        SBPC_MODE_PAR_PROG = 2'b10,
        SBPC_MODE_RSVD     = 2'b11
    } sbpc_mode_t;

    // One-hot select of the monitor comparator for a level code
    function automatic logic sbpc_below(input logic [1:0] lvl,
                                        input logic [3:0] below_vec);
        sbpc_below = below_vec[lvl];
    endfunction : sbpc_below
endpackage : sbpc_pkg

// ---- verilog/sbpc_brownout_chan.sv ----
// One supply brownout channel: picks the trip comparator and gates it.
// Assumes comparator outputs are already synchronous to clk.
`timescale 1ns/100ps
module sbpc_brownout_chan
    import sbpc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] level_sel,
    input  wire logic       reset_off,
    input  wire logic [3:0] below_vec,
    output logic            brownout_q
);
    // Registered brownout request, held while supply is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            brownout_q <= 1'b0;
        end else begin
            brownout_q <= !reset_off && sbpc_below(level_sel, below_vec);
        end
    end
endmodule : sbpc_brownout_chan

// ---- verif/test_supply_brownout_port_config.sv ----
// Self-checking bench for the supply brownout and port config byte.
// Assumes sbpc_pkg is compiled first; assertions live in the design.
`timescale 1ns/100ps
module test_supply_brownout_port_config;
    import sbpc_pkg::*;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [1:0] mode = SBPC_MODE_USER;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [3:0] dig_below = 4'h0;
    logic [3:0] ana_below = 4'h0;
    logic [7:0] rdata;
    logic [1:0] dlvl, alvl;
    logic       aoff, doff, p0g, p23g, p0e, p2e, p3e, bor, wrej;
    int         n_mismatch = 0;
    int         n_compared = 0;
    int         n_rej;

    // Free-running 25 MHz clock
    always #20 clk = ~clk;

    sbpc_config dut (.clk(clk), .reset_n(reset_n), .device_mode(mode),
        .config_address_sfr(addr), .config_wdata(wdata),
        .config_wr(wr), .config_rd(rd), .dig_below(dig_below),
        .ana_below(ana_below), .config_data_sfr(rdata),
        .digital_brownout_level(dlvl), .analog_brownout_level(alvl),
        .analog_brownout_reset_off(aoff),
        .digital_brownout_reset_off(doff),
        .port_zero_gpio_select(p0g), .upper_ports_gpio_select(p23g),
        .p0_ext_bus_en(p0e), .p2_ext_bus_en(p2e), .p3_strobe_en(p3e),
        .brownout_reset(bor), .write_rejected(wrej));

    // Compare and count
    task automatic chk(input string what, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Hold reset for 10 cycles, release on an edge
    task automatic rst();
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask : rst

    // One write strobe, then count rejection pulses over three cycles
    task automatic wr_byte(input logic [1:0] m, input logic [7:0] a, d);
        @(posedge clk);
        mode <= m;
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        n_rej = 0;
        repeat (3) begin
            #1;
            if (wrej !== 1'b0) n_rej++;
            @(posedge clk);
        end
        #1;
    endtask : wr_byte

    // One read strobe, data compared one cycle later
    task automatic rd_chk(input logic [7:0] a, exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1;
        chk("read data", rdata, exp);
    endtask : rd_chk

    // Decoded outputs against a byte value
    task automatic fields(input logic [7:0] b);
        chk("digital level", {6'h00, dlvl}, {6'h00, b[7:6]});
        chk("analog level", {6'h00, alvl}, {6'h00, b[5:4]});
        chk("analog off", {7'h00, aoff}, {7'h00, b[3]});
        chk("digital off", {7'h00, doff}, {7'h00, b[2]});
        chk("port0 gpio", {7'h00, p0g}, {7'h00, b[1]});
        chk("port0 bus", {7'h00, p0e}, {7'h00, ~b[1]});
        chk("upper gpio", {7'h00, p23g}, {7'h00, b[0]});
        chk("port2 bus", {7'h00, p2e}, {7'h00, ~b[0]});
        chk("strobes", {7'h00, p3e}, {7'h00, ~b[1] | ~b[0]});
        rd_chk(SBPC_CFG_ADDR, b);
    endtask : fields

    // Monitor inputs, then reset level after the channel latency
    task automatic bo(input logic [3:0] dv, av, input logic exp);
        @(posedge clk);
        dig_below <= dv;
        ana_below <= av;
        repeat (3) @(posedge clk);
        #1;
        chk("brownout reset", {7'h00, bor}, {7'h00, exp});
    endtask : bo

    // Each code in each field, both programming modes
    task automatic t_levels();
        logic [7:0] b;
        for (logic [2:0] k = 0; k < 4; k++) begin
            b = {k[1:0], ~k[1:0], k[1:0], ~k[1:0]};
            wr_byte(k[0] ? SBPC_MODE_SER_PROG : SBPC_MODE_PAR_PROG,
                    SBPC_CFG_ADDR, b);
            chk("no reject", n_rej[7:0], 8'h00);
            fields(b);
        end
        $display("test levels done");
    endtask : t_levels

    // Writes outside programming modes leave the byte alone
    task automatic t_refuse();
        wr_byte(SBPC_MODE_USER, SBPC_CFG_ADDR, 8'h5A);
        chk("user reject", n_rej[7:0], 8'h01);
        wr_byte(SBPC_MODE_RSVD, SBPC_CFG_ADDR, 8'h5A);
        chk("rsvd reject", n_rej[7:0], 8'h01);
        wr_byte(SBPC_MODE_SER_PROG, 8'h7D, 8'h5A);
        chk("other addr", n_rej[7:0], 8'h00);
        fields(8'hCC);
        rd_chk(8'h7D, SBPC_UNMAPPED_DATA);
        rst();
        fields(SBPC_RESET_VALUE);
        $display("test refuse done");
    endtask : t_refuse

    // Each level code gates its own comparator, disabled channel ignored
    task automatic t_brownout();
        for (logic [2:0] k = 0; k < 4; k++) begin
            wr_byte(SBPC_MODE_SER_PROG, SBPC_CFG_ADDR,
                    {k[1:0], k[1:0], 4'hB});
            bo(~(4'h1 << k[1:0]), 4'hF, 1'b0);
            bo(4'h1 << k[1:0], 4'h0, 1'b1);
            bo(4'h0, 4'h0, 1'b0);
            wr_byte(SBPC_MODE_PAR_PROG, SBPC_CFG_ADDR,
                    {k[1:0], k[1:0], 4'h7});
            bo(4'hF, ~(4'h1 << k[1:0]), 1'b0);
            bo(4'h0, 4'h1 << k[1:0], 1'b1);
            bo(4'h0, 4'h0, 1'b0);
        end
        $display("test brownout done");
    endtask : t_brownout

    // Counts and verdict, then end of run
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        rst();
        #1;
        fields(SBPC_RESET_VALUE);
        t_levels();
        t_refuse();
        t_brownout();
        final_report();
    end

    // Watchdog well past the expected run length
    initial begin
        #(40 * 3000);
        n_mismatch++;
        final_report();
    end
endmodule : test_supply_brownout_port_config
